// ===== cdd_pkg.sv
// package: offsets, fields, reset values and timing for the cpu diag registers
package cdd_pkg;
   // =====================================================
   // register offsets (processor control space)
   localparam logic [15:0] CDD_IRQ_ENABLE_OFF = 16'hc00e;
   localparam logic [15:0] CDD_BREAKPOINT_OFF = 16'hc014;
   localparam logic [15:0] CDD_USB_DIAG_OFF = 16'hc03c;
   localparam logic [15:0] CDD_MEM_DIAG_OFF = 16'hc03e;
   // =====================================================
   // interrupt enable fields
   localparam int CDD_IE_TIMER0_BIT = 0;
   localparam int CDD_IE_TIMER1_BIT = 1;
   localparam int CDD_IE_GPIO_BIT = 2;
   localparam logic [15:0] CDD_IE_OWNED_MASK = 16'h0007;
   // =====================================================
   // usb diagnostic fields
   localparam int CDD_UD_FORCE_LSB = 0;
   localparam int CDD_UD_FS_PULLUP_BIT = 4;
   localparam int CDD_UD_LS_PULLUP_BIT = 5;
   localparam int CDD_UD_PULLDOWN_BIT = 6;
   localparam int CDD_UD_PORT_EN_LSB = 12;
   localparam logic [15:0] CDD_UD_WRITE_MASK = 16'hf077;
   // =====================================================
   // memory diagnostic fields
   localparam int CDD_MD_MONITOR_BIT = 0;
   localparam int CDD_MD_ARB_LSB = 8;
   localparam logic [15:0] CDD_MD_WRITE_MASK = 16'h0701;
   // =====================================================
   // reset values
   localparam logic [15:0] CDD_RESET_WORD = 16'h0000;
   // =====================================================
   // line states driven when a port is forced
   typedef enum logic [1:0] {
      CDD_LINE_K = 2'b00,
      CDD_LINE_J = 2'b01,
      CDD_LINE_SE0 = 2'b10
   } cdd_line_t;
   // =====================================================
   // j/k toggle period
   localparam int CDD_CLK_HZ = 25000000;
   localparam int CDD_TOGGLE_NS = 1000;
   localparam int CDD_TOGGLE_CYC =
      (CDD_TOGGLE_NS * (CDD_CLK_HZ / 1000000)) / 1000;
endpackage

// ===== cdd_throttle.sv
// arbitration throttle: marks n of every 8 memory cycles dead
`timescale 1ns/1ps
module cdd_throttle
   import cdd_pkg::*;
#(
   parameter int SLOTS = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [2:0] i_dead_count,
   output logic o_slot_usable
);
   logic [2:0] slot_reg;
   logic [2:0] slot_next;
   logic usable_reg;
   logic usable_next;

   assign slot_next = slot_reg + 3'h1;
   // slots 0..7-n usable, the last n dead
   assign usable_next = ({1'b0, slot_next} <
      (4'(SLOTS) - {1'b0, i_dead_count}));

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         slot_reg <= 3'h0;
         usable_reg <= 1'b1;
      end else begin
         slot_reg <= slot_next;
         usable_reg <= usable_next;
      end
   end
   assign o_slot_usable = usable_reg;
endmodule

// ===== cdd_regs.sv
// processor control diagnostic registers: irq enables, breakpoint, usb/mem diag
//
// Contract
// - Enable bit 2 gates the gpio interrupt and clearing it drops all pending gpio interrupts.
// - Enable bit 1 gates the second timer interrupt and writing it to zero drops its pending one.
// - Enable bit 0 gates the first timer interrupt and writing it to zero drops its pending one.
// - A 16-bit breakpoint address raises the breakpoint interrupt whenever the program counter equals it.
// - Writing zero to the breakpoint register clears the breakpoint interrupt.
// - The usb diagnostic register is read/write by the cpu but write-only from the host port.
// - Port enables at bits 15..12 apply the selected test conditions to their own port only.
// - Bit 6 connects pull-downs on both data lines of enabled ports.
// - Bit 5 connects a pull-up on d- of enabled ports.
// - Bit 4 connects a pull-up on d+ of enabled ports.
// - Force field 1xx forces se0, 01x toggles j and k, 001 forces j, 000 forces k.
// - Arbitration field n at bits 10:8 leaves n of every 8 memory cycles dead.
// - Monitor bit 0 echoes the internal address bus onto the external address pins.
// - The enable bits live in a read/write register at 0xc00e.
`timescale 1ns/1ps
module cdd_regs
   import cdd_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter int TOGGLE_CYC = CDD_TOGGLE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   // on-chip cpu port
   input wire logic i_cpu_wr,
   input wire logic i_cpu_rd,
   input wire logic [15:0] i_cpu_addr,
   input wire logic [15:0] i_cpu_wdata,
   output logic [15:0] o_cpu_rdata,
   // parallel host port access
   input wire logic i_hpi_wr,
   input wire logic i_hpi_rd,
   input wire logic [15:0] i_hpi_addr,
   input wire logic [15:0] i_hpi_wdata,
   output logic [15:0] o_hpi_rdata,
   // interrupt sources (one-cycle events)
   input wire logic i_gpio_event,
   input wire logic i_timer0_event,
   input wire logic i_timer1_event,
   input wire logic i_gpio_ack,
   input wire logic i_timer0_ack,
   input wire logic i_timer1_ack,
   output logic o_gpio_irq,
   output logic o_first_timer_irq,
   output logic o_second_timer_irq,
   // breakpoint
   input wire logic [15:0] i_pc,
   output logic o_breakpoint_irq_vector,
   // usb port diagnostics, one bit per port
   output logic [NUM_PORTS-1:0] o_diag_force_en,
   output logic [NUM_PORTS-1:0] o_diag_dp,
   output logic [NUM_PORTS-1:0] o_diag_dm,
   output logic [NUM_PORTS-1:0] o_diag_pull_down_resistor,
   output logic [NUM_PORTS-1:0] o_diag_low_speed_resistor,
   output logic [NUM_PORTS-1:0] o_diag_full_speed_resistor,
   // memory diagnostics
   input wire logic [15:0] i_int_addr,
   output logic [15:0] o_ext_addr,
   output logic o_ext_addr_monitor,
   output logic o_mem_slot_usable
);
   // =====================================================
   // access decode
   logic cpu_ie_sel, cpu_bp_sel, cpu_ud_sel, cpu_md_sel;
   logic hpi_ie_sel, hpi_bp_sel, hpi_ud_sel, hpi_md_sel;
   logic wr_ie, wr_bp, wr_ud, wr_md;
   logic [15:0] wdata;

   assign cpu_ie_sel = (i_cpu_addr == CDD_IRQ_ENABLE_OFF);
   assign cpu_bp_sel = (i_cpu_addr == CDD_BREAKPOINT_OFF);
   assign cpu_ud_sel = (i_cpu_addr == CDD_USB_DIAG_OFF);
   assign cpu_md_sel = (i_cpu_addr == CDD_MEM_DIAG_OFF);
   assign hpi_ie_sel = (i_hpi_addr == CDD_IRQ_ENABLE_OFF);
   assign hpi_bp_sel = (i_hpi_addr == CDD_BREAKPOINT_OFF);
   assign hpi_ud_sel = (i_hpi_addr == CDD_USB_DIAG_OFF);
   assign hpi_md_sel = (i_hpi_addr == CDD_MEM_DIAG_OFF);

   // cpu wins a same-cycle collision; host write is dropped then
   assign wr_ie = i_cpu_wr ? cpu_ie_sel : (i_hpi_wr & hpi_ie_sel);
   assign wr_bp = i_cpu_wr ? cpu_bp_sel : (i_hpi_wr & hpi_bp_sel);
   assign wr_ud = i_cpu_wr ? cpu_ud_sel : (i_hpi_wr & hpi_ud_sel);
   assign wr_md = i_cpu_wr ? cpu_md_sel : (i_hpi_wr & hpi_md_sel);
   assign wdata = i_cpu_wr ? i_cpu_wdata : i_hpi_wdata;

   // =====================================================
   // registers
   logic [2:0] ie_reg;
   logic [15:0] bp_reg;
   logic [15:0] ud_reg;
   logic [15:0] md_reg;
   logic [2:0] pend_reg, pend_next;
   logic bp_irq_reg, bp_irq_next;
   logic bp_hit;
   logic [2:0] ev;
   logic [2:0] ack;

   assign ev = {i_gpio_event, i_timer1_event, i_timer0_event};
   assign ack = {i_gpio_ack, i_timer1_ack, i_timer0_ack};

   logic [2:0] ie_eff;
   // pending clear sees the enable value being written this cycle
   assign ie_eff = wr_ie ? wdata[2:0] : ie_reg;
   // cleared enable wipes pending; an event in the same cycle is
   // kept only while its enable stays set
   assign pend_next = (pend_reg & ~ack & ie_eff)
      | (ev & ie_eff);

   assign bp_hit = (i_pc == bp_reg);
   // write of zero clears; a hit in the same cycle is checked against
   // the old value and is dropped
   assign bp_irq_next = (wr_bp && wdata == 16'h0000) ? 1'b0 :
      (bp_irq_reg | bp_hit);

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ie_reg <= 3'h0;
         bp_reg <= CDD_RESET_WORD;
         ud_reg <= CDD_RESET_WORD;
         md_reg <= CDD_RESET_WORD;
      end else begin
         if (wr_ie) begin
            ie_reg <= wdata[2:0];
         end
         if (wr_bp) begin
            bp_reg <= wdata;
         end
         if (wr_ud) begin
            ud_reg <= wdata & CDD_UD_WRITE_MASK;
         end
         if (wr_md) begin
            md_reg <= wdata & CDD_MD_WRITE_MASK;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         pend_reg <= 3'h0;
         bp_irq_reg <= 1'b0;
      end else begin
         pend_reg <= pend_next;
         bp_irq_reg <= bp_irq_next;
      end
   end

   assign o_first_timer_irq = pend_reg[CDD_IE_TIMER0_BIT];
   assign o_second_timer_irq = pend_reg[CDD_IE_TIMER1_BIT];
   assign o_gpio_irq = pend_reg[CDD_IE_GPIO_BIT];
   assign o_breakpoint_irq_vector = bp_irq_reg;

   // =====================================================
   // read paths
   logic [15:0] cpu_rdata_next, hpi_rdata_next;
   logic [15:0] cpu_rdata_reg, hpi_rdata_reg;

   // memory diag reads zero: write-only from both sides
   assign cpu_rdata_next = cpu_ie_sel ? {13'h0, ie_reg} :
      cpu_bp_sel ? bp_reg :
      cpu_ud_sel ? ud_reg : 16'h0000;
   // host port cannot see the usb diag register
   assign hpi_rdata_next = hpi_ie_sel ? {13'h0, ie_reg} :
      hpi_bp_sel ? bp_reg : 16'h0000;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cpu_rdata_reg <= 16'h0000;
         hpi_rdata_reg <= 16'h0000;
      end else begin
         if (i_cpu_rd) begin
            cpu_rdata_reg <= cpu_rdata_next;
         end
         if (i_hpi_rd) begin
            hpi_rdata_reg <= hpi_rdata_next;
         end
      end
   end
   assign o_cpu_rdata = cpu_rdata_reg;
   assign o_hpi_rdata = hpi_rdata_reg;

   // =====================================================
   // usb line forcing
   logic [NUM_PORTS-1:0] port_en;
   logic [2:0] force_sel;
   logic jk_phase_reg;
   logic [15:0] tog_cnt_reg;
   logic tog_tick;
   cdd_line_t line_state;
   logic dp_val, dm_val;

   assign port_en = ud_reg[CDD_UD_PORT_EN_LSB +: NUM_PORTS];
   assign force_sel = ud_reg[CDD_UD_FORCE_LSB +: 3];
   assign tog_tick = (tog_cnt_reg == 16'(TOGGLE_CYC - 1));

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tog_cnt_reg <= 16'h0000;
         jk_phase_reg <= 1'b0;
      end else begin
         tog_cnt_reg <= tog_tick ? 16'h0000 : tog_cnt_reg + 16'h0001;
         if (tog_tick) begin
            jk_phase_reg <= ~jk_phase_reg;
         end
      end
   end

   assign line_state = force_sel[2] ? CDD_LINE_SE0 :
      force_sel[1] ? (jk_phase_reg ? CDD_LINE_J : CDD_LINE_K) :
      force_sel[0] ? CDD_LINE_J : CDD_LINE_K;
   // j is d+ high, k is d- high, se0 both low
   assign dp_val = (line_state == CDD_LINE_J);
   assign dm_val = (line_state == CDD_LINE_K);

   logic [NUM_PORTS-1:0] dp_reg, dm_reg, pd_reg, ls_reg, fs_reg, fe_reg;
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         fe_reg <= '0;
         dp_reg <= '0;
         dm_reg <= '0;
         pd_reg <= '0;
         ls_reg <= '0;
         fs_reg <= '0;
      end else begin
         fe_reg <= port_en;
         dp_reg <= port_en & {NUM_PORTS{dp_val}};
         dm_reg <= port_en & {NUM_PORTS{dm_val}};
         pd_reg <= port_en & {NUM_PORTS{ud_reg[CDD_UD_PULLDOWN_BIT]}};
         ls_reg <= port_en & {NUM_PORTS{ud_reg[CDD_UD_LS_PULLUP_BIT]}};
         fs_reg <= port_en & {NUM_PORTS{ud_reg[CDD_UD_FS_PULLUP_BIT]}};
      end
   end
   assign o_diag_force_en = fe_reg;
   assign o_diag_dp = dp_reg;
   assign o_diag_dm = dm_reg;
   assign o_diag_pull_down_resistor = pd_reg;
   assign o_diag_low_speed_resistor = ls_reg;
   assign o_diag_full_speed_resistor = fs_reg;

   // =====================================================
   // memory diagnostics
   logic [15:0] ext_addr_reg;
   logic mon_reg;
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ext_addr_reg <= 16'h0000;
         mon_reg <= 1'b0;
      end else begin
         mon_reg <= md_reg[CDD_MD_MONITOR_BIT];
         ext_addr_reg <= md_reg[CDD_MD_MONITOR_BIT] ? i_int_addr
            : 16'h0000;
      end
   end
   assign o_ext_addr = ext_addr_reg;
   assign o_ext_addr_monitor = mon_reg;

   cdd_throttle #(
      .SLOTS(8)
   ) u_throttle (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_dead_count(md_reg[CDD_MD_ARB_LSB +: 3]),
      .o_slot_usable(o_mem_slot_usable)
   );

   // =====================================================
   // checks
   property p_ie_clear_drops;
      @(posedge i_clk) disable iff (!i_rst_b)
      (wr_ie && !wdata[CDD_IE_GPIO_BIT]) |=> !o_gpio_irq;
   endproperty
   a_ie_clear_drops: assert property (p_ie_clear_drops)
      else $error("gpio pending survived enable clear");

   property p_t1_clear;
      @(posedge i_clk) disable iff (!i_rst_b)
      (wr_ie && !wdata[CDD_IE_TIMER1_BIT]) |=> !o_second_timer_irq;
   endproperty
   a_t1_clear: assert property (p_t1_clear)
      else $error("timer1 pending survived enable clear");

   property p_t0_event;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_timer0_event && ie_eff[0]) |=> o_first_timer_irq;
   endproperty
   a_t0_event: assert property (p_t0_event)
      else $error("timer0 event lost");

   property p_bp_hit;
      @(posedge i_clk) disable iff (!i_rst_b)
      (bp_hit && !wr_bp) |=> o_breakpoint_irq_vector;
   endproperty
   a_bp_hit: assert property (p_bp_hit)
      else $error("breakpoint match not raised");

   property p_bp_clear;
      @(posedge i_clk) disable iff (!i_rst_b)
      (wr_bp && wdata == 16'h0000) |=> !o_breakpoint_irq_vector;
   endproperty
   a_bp_clear: assert property (p_bp_clear)
      else $error("breakpoint irq not cleared");

   property p_hpi_no_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_hpi_rd && hpi_ud_sel) |=> (o_hpi_rdata == 16'h0000);
   endproperty
   a_hpi_no_read: assert property (p_hpi_no_read)
      else $error("usb diag readable from host port");

   sequence s_port_off;
      !port_en[0];
   endsequence
   property p_port_gate;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_port_off |=> (!o_diag_force_en[0] && !o_diag_pull_down_resistor[0]
         && !o_diag_full_speed_resistor[0]);
   endproperty
   a_port_gate: assert property (p_port_gate)
      else $error("test condition on disabled port");

   property p_se0;
      @(posedge i_clk) disable iff (!i_rst_b)
      (port_en[0] && force_sel[2]) |=> (!o_diag_dp[0] && !o_diag_dm[0]);
   endproperty
   a_se0: assert property (p_se0)
      else $error("se0 not forced");

   property p_monitor;
      @(posedge i_clk) disable iff (!i_rst_b)
      md_reg[CDD_MD_MONITOR_BIT] |=> (o_ext_addr == $past(i_int_addr));
   endproperty
   a_monitor: assert property (p_monitor)
      else $error("address not echoed");
endmodule

// ===== cdd_host_model.sv
// bus model of the on-chip cpu or host port side of the diag registers
`timescale 1ns/1ps
module cdd_host_model
   import cdd_pkg::*;
(
   input wire logic i_clk,
   output logic o_wr,
   output logic o_rd,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
   end
   // =====================================================
   // software side
   // reserved bits of the irq enable, usb diag and mem diag registers written as zero; other addresses keep all 16 bits
   function automatic logic [15:0] keep_mask(input logic [15:0] a);
      case (a)
         CDD_IRQ_ENABLE_OFF: keep_mask = CDD_IE_OWNED_MASK;
         CDD_USB_DIAG_OFF: keep_mask = CDD_UD_WRITE_MASK;
         CDD_MEM_DIAG_OFF: keep_mask = CDD_MD_WRITE_MASK;
         default: keep_mask = 16'hffff;
      endcase
   endfunction
   // one-cycle strobe; idle lines scrambled so stale values never match
   task automatic access(input logic wr, input logic [15:0] a,
                         input logic [15:0] d);
      @(posedge i_clk);
      o_wr <= wr;
      o_rd <= !wr;
      o_addr <= a;
      o_wdata <= d & keep_mask(a);
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
endmodule

// ===== tb_cpu_debug_diag_registers.sv
// self-checking bench for the cpu diagnostic register block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_cpu_debug_diag_registers
   import cdd_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [2:0] ack = 3'h0;
   logic [15:0] pc = 16'h5555;
   logic [15:0] ia = 16'h0000;
   logic cw, cr, hw, hr, bpi, mon, slot;
   logic [15:0] ca, cd, ha, hd, crd, hrd, ext;
   logic [3:0] fe, dp, dm, pd, pl, pf;
   logic [2:0] irq;
   logic [15:0] q_cpu[$];
   logic [15:0] q_hpi[$];
   logic [15:0] regs[4] = '{CDD_IRQ_ENABLE_OFF, CDD_BREAKPOINT_OFF,
                            CDD_USB_DIAG_OFF, CDD_MEM_DIAG_OFF};
   logic cpend = 1'b0;
   logic hpend = 1'b0;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;

   cdd_host_model u_cpu (.i_clk(i_clk), .o_wr(cw), .o_rd(cr), .o_addr(ca),
      .o_wdata(cd));
   cdd_host_model u_hpi (.i_clk(i_clk), .o_wr(hw), .o_rd(hr), .o_addr(ha),
      .o_wdata(hd));
   cdd_regs #(.NUM_PORTS(4), .TOGGLE_CYC(2)) u_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_cpu_wr(cw), .i_cpu_rd(cr), .i_cpu_addr(ca), .i_cpu_wdata(cd),
      .o_cpu_rdata(crd),
      .i_hpi_wr(hw), .i_hpi_rd(hr), .i_hpi_addr(ha), .i_hpi_wdata(hd),
      .o_hpi_rdata(hrd),
      .i_gpio_event(ev[2]), .i_timer0_event(ev[0]), .i_timer1_event(ev[1]),
      .i_gpio_ack(ack[2]), .i_timer0_ack(ack[0]), .i_timer1_ack(ack[1]),
      .o_gpio_irq(irq[2]), .o_first_timer_irq(irq[0]),
      .o_second_timer_irq(irq[1]), .i_pc(pc),
      .o_breakpoint_irq_vector(bpi), .o_diag_force_en(fe),
      .o_diag_dp(dp), .o_diag_dm(dm), .o_diag_pull_down_resistor(pd),
      .o_diag_low_speed_resistor(pl), .o_diag_full_speed_resistor(pf),
      .i_int_addr(ia), .o_ext_addr(ext), .o_ext_addr_monitor(mon),
      .o_mem_slot_usable(slot));

   always #20 i_clk = ~i_clk;

   // =====================================================
   // closing and watchdog
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("[FAIL] %0t run did not finish", $time);
         stop_test();
      end
   end

   // =====================================================
   // read data watcher: oldest note against the answer
   always @(posedge i_clk) begin
      logic [15:0] e;
      if (cpend) begin
         e = q_cpu.pop_front();
         `CHK(crd, e)
      end
      if (hpend) begin
         e = q_hpi.pop_front();
         `CHK(hrd, e)
      end
      cpend = cr;
      hpend = hr;
   end

   // =====================================================
   // access helpers
   task automatic wr(input bit h, input logic [15:0] a, input logic [15:0] d);
      if (h) u_hpi.access(1'b1, a, d);
      else u_cpu.access(1'b1, a, d);
   endtask

   task automatic rd(input bit h, input logic [15:0] a, input logic [15:0] e);
      if (h) q_hpi.push_back(e);
      else q_cpu.push_back(e);
      if (h) u_hpi.access(1'b0, a, 16'h0000);
      else u_cpu.access(1'b0, a, 16'h0000);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   // =====================================================
   // main sequence
   initial begin
      logic [15:0] bp, d;
      logic [3:0] pm, t, k;
      logic [2:0] rs;
      void'($urandom(7871));
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      settle(0);
      `CHK(slot, 1'b1)
      `CHK({fe, pd, pl, pf, bpi, mon}, 18'h0)
      foreach (regs[j]) rd(0, regs[j], CDD_RESET_WORD);
      $display("test reset done");

      for (int i = 0; i < 3; i++) begin
         wr(0, CDD_IRQ_ENABLE_OFF, 16'hffff);
         rd(0, CDD_IRQ_ENABLE_OFF, CDD_IE_OWNED_MASK);
         @(posedge i_clk);
         ev[i] <= 1'b1;
         @(posedge i_clk);
         ev[i] <= 1'b0;
         settle(1);
         `CHK(irq, 3'h1 << i)
         wr(0, CDD_IRQ_ENABLE_OFF, CDD_IE_OWNED_MASK & ~(16'h0001 << i));
         wr(0, CDD_IRQ_ENABLE_OFF, CDD_IE_OWNED_MASK);
         settle(1);
         `CHK(irq, 3'h0)
         @(posedge i_clk);
         ev[i] <= 1'b1;
         @(posedge i_clk);
         ev[i] <= 1'b0;
         settle(0);
         `CHK(irq, 3'h1 << i)
         @(posedge i_clk);
         ack[i] <= 1'b1;
         @(posedge i_clk);
         ack[i] <= 1'b0;
         settle(1);
         `CHK(irq, 3'h0)
      end
      $display("test interrupt enables done");

      bp = 16'($urandom) | 16'h0100;
      @(posedge i_clk);
      pc <= bp ^ 16'h0001;
      wr(1, CDD_BREAKPOINT_OFF, bp);
      rd(0, CDD_BREAKPOINT_OFF, bp);
      settle(1);
      `CHK(bpi, 1'b0)
      @(posedge i_clk);
      pc <= bp;
      @(posedge i_clk);
      pc <= bp ^ 16'h0002;
      settle(1);
      `CHK(bpi, 1'b1)
      wr(0, CDD_BREAKPOINT_OFF, 16'h0000);
      settle(1);
      `CHK(bpi, 1'b0)
      $display("test breakpoint done");

      for (int f = 0; f < 8; f++) begin
         pm = 4'($urandom_range(15, 1));
         rs = 3'($urandom);
         d = {pm, 5'h00, rs, 1'b0, 3'(f)};
         wr(f % 2, CDD_USB_DIAG_OFF, d);
         rd(0, CDD_USB_DIAG_OFF, d);
         rd(1, CDD_USB_DIAG_OFF, 16'h0000);
         settle(0);
         `CHK(fe, pm)
         `CHK(pd, rs[2] ? pm : 4'h0)
         `CHK(pl, rs[1] ? pm : 4'h0)
         `CHK(pf, rs[0] ? pm : 4'h0)
         t = dp & pm;
         if (f > 3) `CHK({t, dm & pm}, 8'h00)
         else if (f == 1) `CHK({t, dm & pm}, {pm, 4'h0})
         else if (f == 0) `CHK({t, dm & pm}, {4'h0, pm})
         else begin
            `CHK(dm & pm, ~t & pm)
            settle(2);
            `CHK(dp & pm, ~t & pm)
         end
      end
      wr(0, CDD_USB_DIAG_OFF, 16'h0075);
      settle(1);
      `CHK({fe, dp, dm, pd, pl, pf}, 24'h0)
      $display("test usb diagnostics done");

      for (int n = 0; n < 8; n++) begin
         wr(n % 2, CDD_MEM_DIAG_OFF, {5'h00, 3'(n), 8'h01});
         rd(0, CDD_MEM_DIAG_OFF, 16'h0000);
         @(posedge i_clk);
         ia <= 16'($urandom);
         settle(2);
         `CHK({mon, ext}, {1'b1, ia})
         k = 4'h0;
         repeat (8) begin
            @(negedge i_clk);
            k = k + {3'h0, slot};
         end
         `CHK(k, 4'(8 - n))
      end
      wr(0, CDD_MEM_DIAG_OFF, 16'h0000);
      wr(0, 16'hc040, 16'hffff);
      rd(0, 16'hc040, 16'h0000);
      settle(1);
      `CHK({mon, ext}, 17'h0)
      $display("test memory diagnostics done");
      stop_test();
   end
endmodule
